/* design/ppa_params.svh */
/*
 * constants of the parallel peripheral adapter: selects, control bits,
 * reset values and handshake timing.
 * assumes inclusion by its bare name from the package and the top module.
 */
`ifndef PPA_PARAMS_SVH
`define PPA_PARAMS_SVH

`define PPA_RS_PORT_A   2'h0
`define PPA_RS_CTRL_A   2'h1
`define PPA_RS_PORT_B   2'h2
`define PPA_RS_CTRL_B   2'h3

`define PPA_CR_IRQ_EN1  0
`define PPA_CR_EDGE1    1
`define PPA_CR_DATA_SEL 2
`define PPA_CR_IRQ_EN2  3
`define PPA_CR_EDGE2    4
`define PPA_CR_C2_OUT   5
`define PPA_CR_FLAG2    6
`define PPA_CR_FLAG1    7

`define PPA_REG_RESET   8'h00

`define PPA_LINE_CA1    0
`define PPA_LINE_CA2    1
`define PPA_LINE_CB1    2
`define PPA_LINE_CB2    3

`define PPA_CLK_PERIOD_NS   20
`define PPA_HS_FALL_MAX_NS  1000
`define PPA_HS_FALL_MAX_CYC (`PPA_HS_FALL_MAX_NS / `PPA_CLK_PERIOD_NS)
`define PPA_HS_RISE_MAX_NS  2000
`define PPA_HS_RISE_MAX_CYC (`PPA_HS_RISE_MAX_NS / `PPA_CLK_PERIOD_NS)

`endif

/* design/ppa_pkg.sv */
/*
 * types of the parallel peripheral adapter.
 * assumes ppa_params.svh is on the include path.
 */
`include "ppa_params.svh"

package ppa_pkg;

    typedef struct packed {
        logic       enable;
        logic       read;
        logic       cs_high_a;
        logic       cs_high_b;
        logic       cs_low_b;
        logic [1:0] rs;
        logic [7:0] data;
        logic [7:0] pa;
        logic [7:0] pb;
        logic [3:0] ctl;
    } ppa_bus_type;

    typedef struct packed {
        logic [7:0] out_a;
        logic [7:0] ddr_a;
        logic [7:0] cr_a;
        logic [7:0] out_b;
        logic [7:0] ddr_b;
        logic [7:0] cr_b;
        logic       ctl_a;
        logic       ctl_b;
    } ppa_regs_type;

    typedef struct packed {
        logic [7:0] data_out;
        logic       data_oe_b;
        logic [7:0] pa_out;
        logic [7:0] pa_oe_b;
        logic [7:0] pb_out;
        logic [7:0] pb_oe_b;
        logic       ca2_out;
        logic       ca2_oe_b;
        logic       cb2_out;
        logic       cb2_oe_b;
        logic       irq_a_oe_b;
        logic       irq_b_oe_b;
    } ppa_pins_type;

    typedef struct packed {
        ppa_bus_type meta;
        ppa_bus_type stable;
    } ppa_sync_state_type;

    typedef struct packed {
        logic last;
        logic primed;
    } ppa_edge_state_type;

    typedef struct packed {
        ppa_regs_type regs;
        ppa_bus_type  hold;
        logic         e_last;
        ppa_pins_type pins;
    } ppa_state_type;

endpackage : ppa_pkg

/* design/ppa_sync.sv */
/*
 * two-stage synchroniser for every pin the adapter samples.
 * assumes inputs are asynchronous to clk_sys.
 */
module ppa_sync
    import ppa_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire ppa_bus_type raw,
    output ppa_bus_type      stable
);

    ppa_sync_state_type st;
    ppa_sync_state_type next_st;

    always_comb begin
        next_st        = st;
        next_st.meta   = raw;
        next_st.stable = st.meta;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign stable = st.stable;

endmodule : ppa_sync

/* design/ppa_edge.sv */
/*
 * strobe-sampled edge detector for one interrupt line.
 * assumes level is synchronised and sample is a one-cycle pulse.
 */
module ppa_edge
    import ppa_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic sample,
    input  wire logic level,
    input  wire logic rising,
    output logic      hit
);

    ppa_edge_state_type st;
    ppa_edge_state_type next_st;

    // first sample after reset only primes; no edge is invented from reset
    always_comb begin
        next_st = st;
        hit     = 1'b0;
        if (sample) begin
            next_st.last   = level;
            next_st.primed = 1'b1;
            hit            = st.primed & (level != st.last) & (level == rising); // RULE29
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule : ppa_edge

/* design/ppa_adapter.sv */
/*
 * dual 8-bit parallel peripheral adapter: processor bus slave, two ports
 * with direction control, edge interrupt lines and handshake control lines.
 * assumes every pin is asynchronous to clk_sys and the strobe is far slower.
 */
//
// Contract
// RULE1 - data bus floats except during selected reads
// RULE2 - all timing follows strobe rising and falling edges
// RULE3 - peripheral holds inactive level one strobe first
// RULE4 - write accepted during strobe with direction low
// RULE5 - read drives bus only while selected and strobed
// RULE6 - reset clears every register bit
// RULE7 - selected when both high selects high, low low
// RULE8 - master holds chip selects stable through strobe
// RULE9 - register chosen by selects plus control bits
// RULE10 - master holds register selects stable through strobe
// RULE11 - interrupt outputs only pull low or float
// RULE12 - two enabled flags drive each interrupt output
// RULE13 - port data read clears that port's flags
// RULE14 - direction bit one output, zero input
// RULE15 - input pins read live onto data bus
// RULE16 - output pins follow output register bits
// RULE17 - port A output bits read sensed pin level
// RULE18 - port B input pins are tri-stated
// RULE19 - port B output bits read register value
// RULE20 - edge inputs set flags, edge chosen by bit
// RULE21 - second control line is input or output
// RULE22 - A handshake falls on read, rises on edge
// RULE23 - B handshake falls on write, rises on edge
// RULE24 - system may gate bus with valid address
// RULE25 - select codes map data, direction and control
// RULE26 - control bits 0-5 writable, 6-7 read-only flags
// RULE27 - bit 0 enables, bit 1 picks edge
// RULE28 - bit 5 low: second line is interrupt input
// RULE29 - edges judged on levels sampled each strobe
`include "ppa_params.svh"

module ppa_adapter
    import ppa_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       bus_enable_strobe,
    input  wire logic       read_write_dir,
    input  wire logic       chip_select_high_a,
    input  wire logic       chip_select_high_b,
    input  wire logic       chip_select_low_b,
    input  wire logic       register_select_low_bit,
    input  wire logic       register_select_high_bit,
    input  wire logic [7:0] cpu_data_lines_in,
    output logic      [7:0] cpu_data_lines_out,
    output logic            cpu_data_lines_oe_b,
    output logic            interrupt_out_port_a_oe_b,
    output logic            interrupt_out_port_b_oe_b,
    input  wire logic [7:0] port_a_pins_in,
    output logic      [7:0] port_a_pins_out,
    output logic      [7:0] port_a_pins_oe_b,
    input  wire logic [7:0] port_b_pins_in,
    output logic      [7:0] port_b_pins_out,
    output logic      [7:0] port_b_pins_oe_b,
    input  wire logic       edge_input_a,
    input  wire logic       edge_input_b,
    input  wire logic       control_line_a_in,
    output logic            control_line_a_out,
    output logic            control_line_a_oe_b,
    input  wire logic       control_line_b_in,
    output logic            control_line_b_out,
    output logic            control_line_b_oe_b
);

    ppa_state_type st;
    ppa_state_type next_st;
    ppa_bus_type   raw;
    ppa_bus_type   bus;

    // one bit per line
    logic [3:0]    edge_rise;
    logic [3:0]    edge_hit;

    logic          e_rise;
    logic          e_fall;
    logic          sel_live;
    logic          sel_held;
    logic          acc_wr;
    logic          acc_rd;
    logic          rd_data_a;
    logic          rd_data_b;
    logic          wr_start_b;
    logic          irq_a;
    logic          irq_b;

    // live read, held write
    function automatic logic selected(input ppa_bus_type b);
        selected = b.cs_high_a & b.cs_high_b & ~b.cs_low_b; // RULE7
    endfunction : selected

    function automatic logic [7:0] read_value(input ppa_regs_type r,
                                              input ppa_bus_type  b);
        read_value = `PPA_REG_RESET;
        unique case (b.rs) // RULE9 RULE25
            `PPA_RS_PORT_A: begin
                if (r.cr_a[`PPA_CR_DATA_SEL]) begin
                    read_value = b.pa; // RULE15 RULE17
                end else begin
                    read_value = r.ddr_a;
                end
            end
            `PPA_RS_CTRL_A: begin
                read_value = r.cr_a;
            end
            `PPA_RS_PORT_B: begin
                if (r.cr_b[`PPA_CR_DATA_SEL]) begin
                    read_value = (r.ddr_b & r.out_b) | (~r.ddr_b & b.pb); // RULE15 RULE19
                end else begin
                    read_value = r.ddr_b;
                end
            end
            `PPA_RS_CTRL_B: begin
                read_value = r.cr_b;
            end
        endcase
    endfunction : read_value

    // every pin, strobe included, is resynchronised before use
    assign raw.enable    = bus_enable_strobe;
    assign raw.read      = read_write_dir;
    assign raw.cs_high_a = chip_select_high_a;
    assign raw.cs_high_b = chip_select_high_b;
    assign raw.cs_low_b  = chip_select_low_b;
    assign raw.rs        = {register_select_high_bit, register_select_low_bit};
    assign raw.data      = cpu_data_lines_in;
    assign raw.pa        = port_a_pins_in;
    assign raw.pb        = port_b_pins_in;
    assign raw.ctl       = {control_line_b_in, edge_input_b, control_line_a_in, edge_input_a};

    // fields move in step
    ppa_sync u_sync (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .raw     (raw),
        .stable  (bus)
    );

    // 1 rising, 0 falling
    assign edge_rise[`PPA_LINE_CA1] = st.regs.cr_a[`PPA_CR_EDGE1]; // RULE27
    assign edge_rise[`PPA_LINE_CA2] = st.regs.cr_a[`PPA_CR_EDGE2]; // RULE28
    assign edge_rise[`PPA_LINE_CB1] = st.regs.cr_b[`PPA_CR_EDGE1]; // RULE27
    assign edge_rise[`PPA_LINE_CB2] = st.regs.cr_b[`PPA_CR_EDGE2]; // RULE28

    // lines are judged only at strobe ends, so a glitch between strobes is lost
    for (genvar i = 0; i < 4; i++) begin : g_edge
        ppa_edge u_edge (
            .clk_sys (clk_sys),
            .rst_b   (rst_b),
            .sample  (e_fall),
            .level   (bus.ctl[i]),
            .rising  (edge_rise[i]),
            .hit     (edge_hit[i])
        ); // RULE3 RULE20
    end

    always_comb begin
        next_st = st;

        // pin edge + 2 cycles
        e_rise = bus.enable & ~st.e_last; // RULE2
        e_fall = ~bus.enable & st.e_last; // RULE2
        next_st.e_last = bus.enable;

        // the data hold after the strobe is shorter than the sync delay,
        // so the bus is captured while the strobe is still seen high
        if (bus.enable) begin
            next_st.hold = bus;
        end

        // held copy picks writes
        sel_live = selected(bus);
        sel_held = selected(st.hold);
        acc_wr   = e_fall & sel_held & ~st.hold.read;
        acc_rd   = e_fall & sel_held & st.hold.read;

        rd_data_a = acc_rd & (st.hold.rs == `PPA_RS_PORT_A)
                  & st.regs.cr_a[`PPA_CR_DATA_SEL];
        rd_data_b = acc_rd & (st.hold.rs == `PPA_RS_PORT_B)
                  & st.regs.cr_b[`PPA_CR_DATA_SEL];
        // starts at strobe rise
        wr_start_b = e_rise & sel_live & ~bus.read & (bus.rs == `PPA_RS_PORT_B)
                   & st.regs.cr_b[`PPA_CR_DATA_SEL];

        if (acc_wr) begin // RULE4
            unique case (st.hold.rs) // RULE9 RULE25
                `PPA_RS_PORT_A: begin
                    if (st.regs.cr_a[`PPA_CR_DATA_SEL]) begin
                        next_st.regs.out_a = st.hold.data;
                    end else begin
                        next_st.regs.ddr_a = st.hold.data;
                    end
                end
                `PPA_RS_CTRL_A: begin
                    // flags stay read-only
                    next_st.regs.cr_a[5:0] = st.hold.data[5:0]; // RULE26
                end
                `PPA_RS_PORT_B: begin
                    if (st.regs.cr_b[`PPA_CR_DATA_SEL]) begin
                        next_st.regs.out_b = st.hold.data;
                    end else begin
                        next_st.regs.ddr_b = st.hold.data;
                    end
                end
                `PPA_RS_CTRL_B: begin
                    next_st.regs.cr_b[5:0] = st.hold.data[5:0]; // RULE26
                end
            endcase
        end

        // a new edge in the clearing cycle survives the clear
        next_st.regs.cr_a[`PPA_CR_FLAG1] = (st.regs.cr_a[`PPA_CR_FLAG1] & ~rd_data_a)
                                         | edge_hit[`PPA_LINE_CA1]; // RULE13 RULE20
        next_st.regs.cr_a[`PPA_CR_FLAG2] = (st.regs.cr_a[`PPA_CR_FLAG2] & ~rd_data_a)
                                         | (edge_hit[`PPA_LINE_CA2]
                                            & ~st.regs.cr_a[`PPA_CR_C2_OUT]); // RULE13 RULE28
        next_st.regs.cr_b[`PPA_CR_FLAG1] = (st.regs.cr_b[`PPA_CR_FLAG1] & ~rd_data_b)
                                         | edge_hit[`PPA_LINE_CB1]; // RULE13 RULE20
        next_st.regs.cr_b[`PPA_CR_FLAG2] = (st.regs.cr_b[`PPA_CR_FLAG2] & ~rd_data_b)
                                         | (edge_hit[`PPA_LINE_CB2]
                                            & ~st.regs.cr_b[`PPA_CR_C2_OUT]); // RULE13 RULE28

        // bit 4 set: level from bit 3
        if (next_st.regs.cr_a[`PPA_CR_C2_OUT]) begin // RULE21
            if (next_st.regs.cr_a[`PPA_CR_EDGE2]) begin
                next_st.regs.ctl_a = next_st.regs.cr_a[`PPA_CR_IRQ_EN2];
            end else if (edge_hit[`PPA_LINE_CA1]) begin
                next_st.regs.ctl_a = 1'b1; // RULE22
            end else if (rd_data_a) begin
                next_st.regs.ctl_a = 1'b0; // RULE22
            end
        end

        // edge raises, write lowers
        if (next_st.regs.cr_b[`PPA_CR_C2_OUT]) begin // RULE21
            if (next_st.regs.cr_b[`PPA_CR_EDGE2]) begin
                next_st.regs.ctl_b = next_st.regs.cr_b[`PPA_CR_IRQ_EN2];
            end else if (edge_hit[`PPA_LINE_CB1]) begin
                next_st.regs.ctl_b = 1'b1; // RULE23
            end else if (wr_start_b) begin
                next_st.regs.ctl_b = 1'b0; // RULE23
            end
        end

        // enable raised over a flag already set asserts at once
        irq_a = (next_st.regs.cr_a[`PPA_CR_FLAG1] & next_st.regs.cr_a[`PPA_CR_IRQ_EN1])
              | (next_st.regs.cr_a[`PPA_CR_FLAG2] & next_st.regs.cr_a[`PPA_CR_IRQ_EN2]
                 & ~next_st.regs.cr_a[`PPA_CR_C2_OUT]); // RULE12 RULE27
        irq_b = (next_st.regs.cr_b[`PPA_CR_FLAG1] & next_st.regs.cr_b[`PPA_CR_IRQ_EN1])
              | (next_st.regs.cr_b[`PPA_CR_FLAG2] & next_st.regs.cr_b[`PPA_CR_IRQ_EN2]
                 & ~next_st.regs.cr_b[`PPA_CR_C2_OUT]); // RULE12 RULE27

        // no decode glitch on pins
        next_st.pins.data_oe_b  = ~(bus.enable & sel_live & bus.read); // RULE1 RULE5
        next_st.pins.data_out   = read_value(st.regs, bus); // RULE5
        next_st.pins.pa_out     = next_st.regs.out_a; // RULE16
        next_st.pins.pa_oe_b    = ~next_st.regs.ddr_a; // RULE14
        next_st.pins.pb_out     = next_st.regs.out_b; // RULE16
        next_st.pins.pb_oe_b    = ~next_st.regs.ddr_b; // RULE14 RULE18
        next_st.pins.ca2_out    = next_st.regs.ctl_a;
        next_st.pins.ca2_oe_b   = ~next_st.regs.cr_a[`PPA_CR_C2_OUT]; // RULE21
        next_st.pins.cb2_out    = next_st.regs.ctl_b;
        next_st.pins.cb2_oe_b   = ~next_st.regs.cr_b[`PPA_CR_C2_OUT]; // RULE21
        next_st.pins.irq_a_oe_b = ~irq_a; // RULE11
        next_st.pins.irq_b_oe_b = ~irq_b; // RULE11
    end

    // registers clear to zero, pin enables to released
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st                 <= '0; // RULE6
            st.pins.data_oe_b  <= 1'b1;
            st.pins.pa_oe_b    <= 8'hff;
            st.pins.pb_oe_b    <= 8'hff;
            st.pins.ca2_oe_b   <= 1'b1;
            st.pins.cb2_oe_b   <= 1'b1;
            st.pins.irq_a_oe_b <= 1'b1;
            st.pins.irq_b_oe_b <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // plain copies
    assign cpu_data_lines_out        = st.pins.data_out;
    assign cpu_data_lines_oe_b       = st.pins.data_oe_b;
    assign interrupt_out_port_a_oe_b = st.pins.irq_a_oe_b;
    assign interrupt_out_port_b_oe_b = st.pins.irq_b_oe_b;
    assign port_a_pins_out           = st.pins.pa_out;
    assign port_a_pins_oe_b          = st.pins.pa_oe_b;
    assign port_b_pins_out           = st.pins.pb_out;
    assign port_b_pins_oe_b          = st.pins.pb_oe_b;
    assign control_line_a_out        = st.pins.ca2_out;
    assign control_line_a_oe_b       = st.pins.ca2_oe_b;
    assign control_line_b_out        = st.pins.cb2_out;
    assign control_line_b_oe_b       = st.pins.cb2_oe_b;

endmodule : ppa_adapter

/* sim/ppa_peripheral.sv */
/*
 * peripheral side of the adapter: resolves port pins and control lines.
 * assumes the bench sets the peripheral's drive levels and pin loading.
 */
`include "ppa_params.svh"

module ppa_peripheral
    import ppa_pkg::*;
(
    input  wire logic         [15:0] load,
    input  wire ppa_pins_type        dut_pins,
    input  wire ppa_bus_type         drv,
    output ppa_bus_type              seen
);
    timeunit 1ns;
    timeprecision 1ps;

    always_comb begin
        seen = '0;
        // load bits model a pin dragged low by a heavy load
        for (int i = 0; i < 8; i++) begin
            seen.pa[i] = dut_pins.pa_oe_b[i] ? drv.pa[i] : dut_pins.pa_out[i] & !load[8 + i];
            seen.pb[i] = dut_pins.pb_oe_b[i] ? drv.pb[i] : dut_pins.pb_out[i] & !load[i];
        end
        // edge levels only change between strobes
        seen.ctl = drv.ctl;
        if (!dut_pins.ca2_oe_b) begin
            seen.ctl[`PPA_LINE_CA2] = dut_pins.ca2_out;
        end
        if (!dut_pins.cb2_oe_b) begin
            seen.ctl[`PPA_LINE_CB2] = dut_pins.cb2_out;
        end
    end
endmodule : ppa_peripheral

/* sim/ppa_adapter_sva.sv */
/*
 * pin-level assertions for the parallel peripheral adapter.
 * assumes strobes last several clk_sys cycles; bound into ppa_adapter.
 */
module ppa_adapter_sva (
    input wire logic       clk_sys,
    input wire logic       rst_b,
    input wire logic       bus_enable_strobe,
    input wire logic       read_write_dir,
    input wire logic       chip_select_high_a,
    input wire logic       chip_select_high_b,
    input wire logic       chip_select_low_b,
    input wire logic       cpu_data_lines_oe_b,
    input wire logic       interrupt_out_port_a_oe_b,
    input wire logic       interrupt_out_port_b_oe_b,
    input wire logic [7:0] port_a_pins_out,
    input wire logic [7:0] port_a_pins_oe_b,
    input wire logic [7:0] port_b_pins_out,
    input wire logic [7:0] port_b_pins_oe_b,
    input wire logic       control_line_a_oe_b,
    input wire logic       control_line_b_oe_b
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    logic sel;
    assign sel = chip_select_high_a && chip_select_high_b && !chip_select_low_b;

    a_reset_all_float: assert property ($rose(rst_b) |-> cpu_data_lines_oe_b
        && interrupt_out_port_a_oe_b && interrupt_out_port_b_oe_b && control_line_a_oe_b
        && control_line_b_oe_b && (&port_a_pins_oe_b) && (&port_b_pins_oe_b))
        else $error("outputs driven right after reset");
    a_unselected_float: assert property (!sel [*6] |-> cpu_data_lines_oe_b)
        else $error("data bus driven while unselected");
    a_write_float: assert property (!read_write_dir [*6] |-> cpu_data_lines_oe_b)
        else $error("data bus driven during write");
    a_idle_float: assert property (!bus_enable_strobe [*6] |-> cpu_data_lines_oe_b)
        else $error("data bus driven without strobe");
    a_read_drives: assert property ((bus_enable_strobe && sel && read_write_dir) [*5]
        |-> !cpu_data_lines_oe_b)
        else $error("selected read not driven");
    a_strobe_release: assert property ($fell(bus_enable_strobe)
        |-> ##[1:5] cpu_data_lines_oe_b)
        else $error("data bus held after strobe end");
    a_irq_strobe_only: assert property (!bus_enable_strobe [*8]
        |-> $stable({interrupt_out_port_a_oe_b, interrupt_out_port_b_oe_b}))
        else $error("interrupt changed between strobes");
    a_pins_strobe_only: assert property (!bus_enable_strobe [*8]
        |-> $stable({port_a_pins_out, port_a_pins_oe_b, port_b_pins_out, port_b_pins_oe_b,
        control_line_a_oe_b, control_line_b_oe_b}))
        else $error("port outputs changed between strobes");
endmodule : ppa_adapter_sva

bind ppa_adapter ppa_adapter_sva i_sva (
    .clk_sys,
    .rst_b,
    .bus_enable_strobe,
    .read_write_dir,
    .chip_select_high_a,
    .chip_select_high_b,
    .chip_select_low_b,
    .cpu_data_lines_oe_b,
    .interrupt_out_port_a_oe_b,
    .interrupt_out_port_b_oe_b,
    .port_a_pins_out,
    .port_a_pins_oe_b,
    .port_b_pins_out,
    .port_b_pins_oe_b,
    .control_line_a_oe_b,
    .control_line_b_oe_b
);

/* sim/testbench.sv */
/*
 * self-checking bench: strobed register accesses, ports, flags, handshakes.
 * assumes the adapter, its checker and the peripheral model are compiled.
 */
`include "ppa_params.svh"

module testbench
    import ppa_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                clk_sys    = 1'b0;
    logic                rst_b      = 1'b0;
    logic         [15:0] load       = 16'h0000;
    int                  bad_count  = 0;
    int                  n_compared = 0;
    int                  cycles     = 0;
    ppa_bus_type         drv;
    wire ppa_bus_type    seen;
    wire ppa_pins_type   pins;
    localparam logic [2:0] sel_ok = 3'b110;

    always #10 clk_sys = ~clk_sys;

    ppa_adapter i_dut (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .bus_enable_strobe(drv.enable),
        .read_write_dir(drv.read),
        .chip_select_high_a(drv.cs_high_a),
        .chip_select_high_b(drv.cs_high_b),
        .chip_select_low_b(drv.cs_low_b),
        .register_select_low_bit(drv.rs[0]),
        .register_select_high_bit(drv.rs[1]),
        .cpu_data_lines_in(drv.data),
        .cpu_data_lines_out(pins.data_out),
        .cpu_data_lines_oe_b(pins.data_oe_b),
        .interrupt_out_port_a_oe_b(pins.irq_a_oe_b),
        .interrupt_out_port_b_oe_b(pins.irq_b_oe_b),
        .port_a_pins_in(seen.pa),
        .port_a_pins_out(pins.pa_out),
        .port_a_pins_oe_b(pins.pa_oe_b),
        .port_b_pins_in(seen.pb),
        .port_b_pins_out(pins.pb_out),
        .port_b_pins_oe_b(pins.pb_oe_b),
        .edge_input_a(seen.ctl[`PPA_LINE_CA1]),
        .edge_input_b(seen.ctl[`PPA_LINE_CB1]),
        .control_line_a_in(seen.ctl[`PPA_LINE_CA2]),
        .control_line_a_out(pins.ca2_out),
        .control_line_a_oe_b(pins.ca2_oe_b),
        .control_line_b_in(seen.ctl[`PPA_LINE_CB2]),
        .control_line_b_out(pins.cb2_out),
        .control_line_b_oe_b(pins.cb2_oe_b)
    );

    ppa_peripheral i_peripheral (
        .load(load),
        .dut_pins(pins),
        .drv(drv),
        .seen(seen)
    );

    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one strobed access; selects stay put for the whole strobe
    task automatic acc(input logic [2:0] sel, input logic [1:0] r, input logic rd,
                       input logic [7:0] wd, input logic [7:0] exp);
        @(posedge clk_sys);
        #2;
        {drv.cs_high_a, drv.cs_high_b, drv.cs_low_b} = sel;
        drv.rs = r;
        drv.read = rd;
        drv.data = wd;
        @(posedge clk_sys);
        #2;
        drv.enable = 1'b1;
        repeat (6) @(posedge clk_sys);
        #2;
        chk(8'(pins.data_oe_b), 8'(!(sel == sel_ok && rd)));
        if (sel == sel_ok && rd) begin
            chk(pins.data_out, exp);
        end
        drv.enable = 1'b0;
        repeat (6) @(posedge clk_sys);
        #2;
        drv.cs_low_b = 1'b1;
        drv.read = 1'b1;
    endtask : acc

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        // a full run needs about 650 cycles
        if (cycles == 4000) begin
            bad_count++;
            close_out();
        end
    end

    initial begin
        logic [2:0] bad [4];
        bad = '{3'b111, 3'b010, 3'b100, 3'b000};
        drv = '0;
        drv.read = 1'b1;
        drv.cs_low_b = 1'b1;
        drv.ctl = 4'h3;
        drv.pa = 8'h3C;
        drv.pb = 8'h9C;
        repeat (12) @(posedge clk_sys);
        #2;
        rst_b = 1'b1;
        repeat (3) @(posedge clk_sys);
        #2;
        chk({pins.pa_oe_b[0], pins.pb_oe_b[0], pins.ca2_oe_b, pins.cb2_oe_b, 4'hF}, 8'hFF);
        acc(sel_ok, 2'h1, 1'b1, 8'h00, 8'h00);
        acc(sel_ok, 2'h0, 1'b0, 8'h0F, 8'h00);
        acc(sel_ok, 2'h0, 1'b1, 8'h00, 8'h0F);
        acc(sel_ok, 2'h1, 1'b0, 8'hFF, 8'h00);
        acc(sel_ok, 2'h1, 1'b1, 8'h00, 8'h3F);
        acc(sel_ok, 2'h1, 1'b0, 8'h04, 8'h00);
        acc(sel_ok, 2'h0, 1'b0, 8'hA5, 8'h00);
        chk(pins.pa_oe_b, 8'hF0);
        chk(pins.pa_out, 8'hA5);
        acc(sel_ok, 2'h0, 1'b1, 8'h00, 8'h35);
        load = 16'h0100;
        acc(sel_ok, 2'h0, 1'b1, 8'h00, 8'h34);
        acc(sel_ok, 2'h2, 1'b0, 8'hF0, 8'h00);
        acc(sel_ok, 2'h3, 1'b0, 8'h04, 8'h00);
        load = 16'h0040;
        acc(sel_ok, 2'h2, 1'b0, 8'h5A, 8'h00);
        chk(pins.pb_oe_b, 8'h0F);
        chk(pins.pb_out, 8'h5A);
        acc(sel_ok, 2'h2, 1'b1, 8'h00, 8'h5C);
        load = 16'h0000;
        foreach (bad[i]) begin
            acc(bad[i], 2'h1, 1'b0, 8'h3F, 8'h00);
            acc(bad[i], 2'h1, 1'b1, 8'h00, 8'h00);
        end
        acc(sel_ok, 2'h1, 1'b1, 8'h00, 8'h04);
        acc(sel_ok, 2'h1, 1'b0, 8'h05, 8'h00);
        drv.ctl[`PPA_LINE_CA1] = 1'b0;
        acc(sel_ok, 2'h1, 1'b1, 8'h00, 8'h05);
        acc(sel_ok, 2'h1, 1'b1, 8'h00, 8'h85);
        chk(8'(pins.irq_a_oe_b), 8'h00);
        drv.ctl[`PPA_LINE_CA1] = 1'b1;
        acc(sel_ok, 2'h0, 1'b1, 8'h00, 8'h35);
        chk(8'(pins.irq_a_oe_b), 8'h01);
        acc(sel_ok, 2'h1, 1'b1, 8'h00, 8'h05);
        acc(sel_ok, 2'h1, 1'b0, 8'h0C, 8'h00);
        drv.ctl[`PPA_LINE_CA2] = 1'b0;
        acc(sel_ok, 2'h1, 1'b1, 8'h00, 8'h0C);
        acc(sel_ok, 2'h1, 1'b1, 8'h00, 8'h4C);
        chk(8'(pins.irq_a_oe_b), 8'h00);
        drv.ctl[`PPA_LINE_CA2] = 1'b1;
        acc(sel_ok, 2'h0, 1'b1, 8'h00, 8'h35);
        acc(sel_ok, 2'h1, 1'b1, 8'h00, 8'h0C);
        acc(sel_ok, 2'h3, 1'b0, 8'h06, 8'h00);
        drv.ctl[`PPA_LINE_CB1] = 1'b1;
        acc(sel_ok, 2'h3, 1'b1, 8'h00, 8'h06);
        acc(sel_ok, 2'h3, 1'b1, 8'h00, 8'h86);
        chk(8'(pins.irq_b_oe_b), 8'h01);
        acc(sel_ok, 2'h3, 1'b0, 8'h07, 8'h00);
        chk(8'(pins.irq_b_oe_b), 8'h00);
        acc(sel_ok, 2'h2, 1'b1, 8'h00, 8'h5C);
        chk(8'(pins.irq_b_oe_b), 8'h01);
        acc(sel_ok, 2'h1, 1'b0, 8'h3C, 8'h00);
        chk(8'({pins.ca2_oe_b, pins.ca2_out}), 8'h01);
        acc(sel_ok, 2'h1, 1'b0, 8'h34, 8'h00);
        chk(8'({pins.ca2_oe_b, pins.ca2_out}), 8'h00);
        acc(sel_ok, 2'h1, 1'b0, 8'h24, 8'h00);
        drv.ctl[`PPA_LINE_CA1] = 1'b0;
        acc(sel_ok, 2'h1, 1'b1, 8'h00, 8'h24);
        chk(8'(pins.ca2_out), 8'h01);
        acc(sel_ok, 2'h0, 1'b1, 8'h00, 8'h35);
        chk(8'(pins.ca2_out), 8'h00);
        acc(sel_ok, 2'h3, 1'b0, 8'h24, 8'h00);
        drv.ctl[`PPA_LINE_CB1] = 1'b0;
        acc(sel_ok, 2'h3, 1'b1, 8'h00, 8'h24);
        chk(8'({pins.cb2_oe_b, pins.cb2_out}), 8'h01);
        acc(sel_ok, 2'h2, 1'b0, 8'h5A, 8'h00);
        chk(8'({pins.cb2_oe_b, pins.cb2_out}), 8'h00);
        close_out();
    end
endmodule : testbench
